// ==== sac_control.sv ====
// Converter control block: APB registers, channel and pin takeover, sequencing and formats.
// Assumes an APB master on pclk and an analog front end with mux, trial DAC and comparator.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "sac_defs.svh"

// Overview of operation
// - One of 24 inputs routed by channel field.
// - Selected channel pin forced to converter input.
// - Port data and direction ignored on selected pin.
// - Port read of selected pin returns zero.
// - Upper reference gives 3FF, lower gives 000.
// - Control write starts conversion, 16 to 17 ticks.
// - Continuous mode overwrites results until cleared.
// - Flag set at completion, cleared by result read.
// - Single mode converts once per control write.
// - Two clock-register bits select four formats.
// - Left: eight top bits high, two low.
// - High read locks results until low read.
// - Right: two top bits high, eight low.
// - Signed left inverts the result top bit.
// - Truncation: top eight bits low, no lock.
// - Interrupt enable raises interrupt, flag unused.
// - Converter runs in wait, interrupt wakes processor.
// - Stop mode aborts conversion, converter goes inactive.
// - Continuous conversions resume after stop, allow settling.
// - Pending interrupt cleared by result read or control write.
// - All-ones channel field switches converter off.
// - Flag never set, reads zero, with interrupts enabled.
// - Five-bit channel field, 0 to 23 external.
module sac_control
   import sac_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        wait_mode,
   input  wire logic        stop_mode,
   input  wire logic        cmp_above,
   output logic [4:0]       mux_select,
   output logic [9:0]       trial_code,
   output logic             sample_hold,
   output logic             conv_power_down,
   output logic             conv_irq,
   output logic [23:0]      pin_analog_sel,
   input  wire logic [23:0] port_data_out,
   input  wire logic [23:0] port_dir_out,
   input  wire logic [23:0] pin_level_in,
   output logic [23:0]      pin_drive_out,
   output logic [23:0]      pin_drive_oe,
   output logic [23:0]      port_read_data
);

   logic [7:0]  scr_q;
   logic [7:0]  clk_cfg_q;
   logic [7:0]  result_high_q;
   logic [7:0]  result_low_q;
   logic        flag_q;
   logic        irq_q;
   logic        lock_q;
   logic        stop_q;
   logic [3:0]  div_cnt_q;
   logic [23:0] pin_out_q;
   logic [23:0] pin_oe_q;
   logic [23:0] port_rd_q;
   logic [23:0] chan_onehot;
   logic        wr_access;
   logic        rd_access;
   logic        addr_ok;
   logic        scr_write;
   logic        high_read;
   logic        low_read;
   logic        result_read;
   logic        irq_enabled;
   logic        continuous;
   logic        powered_off;
   logic [4:0]  channel;
   sac_format_t fmt;
   logic [2:0]  div_sel;
   logic [3:0]  div_last;
   logic        conv_tick;
   logic        eng_start;
   logic        eng_abort;
   logic        eng_busy;
   logic        eng_done;
   logic [9:0]  eng_result;
   logic        store_ok;
   logic        stop_exit;
   logic        chan_off_next;
   logic [7:0]  fmt_high;
   logic [7:0]  fmt_low;
   logic [7:0]  rd_byte;

   // Field views of the control and clock registers.
   assign channel     = scr_q[`SAC_SCR_CHAN_MSB:0];
   assign continuous  = scr_q[`SAC_SCR_CONT_BIT];
   assign irq_enabled = scr_q[`SAC_SCR_IRQEN_BIT];
   assign powered_off = (channel == `SAC_CHAN_POWER_OFF);
   assign fmt         = sac_format_t'(clk_cfg_q[`SAC_CLK_FMT_MSB:`SAC_CLK_FMT_LSB]);
   assign div_sel     = clk_cfg_q[`SAC_CLK_DIV_MSB:`SAC_CLK_DIV_LSB];

   // APB decode; every access completes with no wait state.
   assign wr_access   = psel && penable && pwrite;
   assign rd_access   = psel && penable && !pwrite;
   assign addr_ok     = (paddr == `SAC_OFF_STATUS_CTRL) || (paddr == `SAC_OFF_RESULT_HIGH) ||
                        (paddr == `SAC_OFF_RESULT_LOW)  || (paddr == `SAC_OFF_CLOCK_CFG);
   assign pready      = 1'b1;
   assign pslverr     = psel && penable && !addr_ok;
   assign scr_write   = wr_access && pstrb[0] && paddr == `SAC_OFF_STATUS_CTRL;
   assign high_read   = rd_access && paddr == `SAC_OFF_RESULT_HIGH;
   assign low_read    = rd_access && paddr == `SAC_OFF_RESULT_LOW;
   assign result_read = high_read || low_read;

   // Read mux: each register is one byte in the low lane, upper bits zero.
   always_comb begin
      rd_byte = 8'h00;
      case (paddr)
         `SAC_OFF_STATUS_CTRL: begin
            rd_byte = {flag_q && !irq_enabled, scr_q[6:0]};
         end
         `SAC_OFF_RESULT_HIGH: begin
            rd_byte = result_high_q;
         end
         `SAC_OFF_RESULT_LOW: begin
            rd_byte = result_low_q;
         end
         `SAC_OFF_CLOCK_CFG: begin
            rd_byte = clk_cfg_q;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
      prdata = {24'h000000, rd_byte};
   end

   // Control register; the flag position is read-only and never stored.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scr_q <= `SAC_SCR_RESET;
      end else if (scr_write) begin
         scr_q <= {1'b0, pwdata[6:0]};
      end
   end

   // Clock configuration register with divider, input select and format fields.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_cfg_q <= `SAC_CLK_RESET;
      end else if (wr_access && pstrb[0] && paddr == `SAC_OFF_CLOCK_CFG) begin
         clk_cfg_q <= pwdata[7:0];
      end
   end

   // Converter clock enable: one pulse every 2^n bus cycles, n limited to four.
   assign div_last  = (div_sel > `SAC_DIV_MAX) ? 4'hF : 4'((5'h01 << div_sel) - 5'h01);
   assign conv_tick = (div_cnt_q >= div_last) && !powered_off && !stop_mode;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= 4'h0;
      end else if (conv_tick || powered_off || stop_mode) begin
         div_cnt_q <= 4'h0;
      end else begin
         div_cnt_q <= div_cnt_q + 4'h1;
      end
   end

   // Stop mode tracking so that continuous conversions resume on its release.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_q <= 1'b0;
      end else begin
         stop_q <= stop_mode;
      end
   end
   assign stop_exit = stop_q && !stop_mode;

   // Start on a control write, or in continuous mode on each completion or after stop.
   // Wait mode is deliberately not looked at: the converter keeps running through it.
   // A control write is judged by the channel being written, so leaving power-off starts.
   assign chan_off_next = scr_write ? (pwdata[`SAC_SCR_CHAN_MSB:0] == `SAC_CHAN_POWER_OFF) :
                          powered_off;
   assign eng_abort = stop_mode || chan_off_next;
   assign eng_start = !eng_abort &&
                      (scr_write ||
                       (eng_done && continuous) ||
                       (stop_exit && continuous));

   sac_sar_engine u_engine (
      .pclk        (pclk),
      .presetn     (presetn),
      .conv_tick   (conv_tick),
      .start       (eng_start),
      .abort       (eng_abort),
      .cmp_above   (cmp_above),
      .trial_code  (trial_code),
      .sample_hold (sample_hold),
      .busy        (eng_busy),
      .done        (eng_done),
      .result      (eng_result)
   );

   // Result formatting for the four formats.
   always_comb begin
      fmt_high = 8'h00;
      fmt_low  = 8'h00;
      case (fmt)
         SAC_FMT_LEFT: begin
            fmt_high = eng_result[9:2];
            fmt_low  = {eng_result[1:0], 6'h00};
         end
         SAC_FMT_RIGHT: begin
            fmt_high = {6'h00, eng_result[9:8]};
            fmt_low  = eng_result[7:0];
         end
         SAC_FMT_LEFT_SIGNED: begin
            fmt_high = {~eng_result[9], eng_result[8:2]};
            fmt_low  = {eng_result[1:0], 6'h00};
         end
         SAC_FMT_TRUNC8: begin
            fmt_high = 8'h00;
            fmt_low  = eng_result[9:2];
         end
         default: begin
            fmt_high = 8'h00;
            fmt_low  = 8'h00;
         end
      endcase
   end

   // High/low interlock: a high read freezes the results until the low read, except in the truncation format.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_q <= 1'b0;
      end else if (low_read || fmt == SAC_FMT_TRUNC8) begin
         lock_q <= 1'b0;
      end else if (high_read) begin
         lock_q <= 1'b1;
      end
   end
   assign store_ok = eng_done && (!lock_q || fmt == SAC_FMT_TRUNC8);

   // Result registers, overwritten at each completion unless locked.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_high_q <= 8'h00;
         result_low_q  <= 8'h00;
      end else if (store_ok) begin
         result_high_q <= fmt_high;
         result_low_q  <= fmt_low;
      end
   end

   // Completion flag, used only with interrupts disabled; a new completion beats the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (eng_done && !irq_enabled) begin
         flag_q <= 1'b1;
      end else if (result_read || irq_enabled) begin
         flag_q <= 1'b0;
      end
   end

   // Interrupt pending; it also serves as the wake request out of wait mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else if (eng_done && irq_enabled) begin
         irq_q <= 1'b1;
      end else if (result_read || scr_write || !irq_enabled) begin
         irq_q <= 1'b0;
      end
   end
   assign conv_irq = irq_q;

   // Analog mux select and power-down outputs.
   assign mux_select      = channel;
   assign conv_power_down = powered_off || stop_mode;

   // One-hot pin takeover, one entry per external channel.
   genvar gi;
   generate
      for (gi = 0; gi < `SAC_CHAN_COUNT; gi++) begin : g_pin
         assign chan_onehot[gi] = (channel == 5'(gi));
      end
   endgenerate
   assign pin_analog_sel = chan_onehot;

   // Pin drive and port read-back, registered, with the taken pin masked off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_q <= 24'h000000;
         pin_oe_q  <= 24'h000000;
         port_rd_q <= 24'h000000;
      end else begin
         pin_out_q <= port_data_out & ~chan_onehot;
         pin_oe_q  <= port_dir_out & ~chan_onehot;
         port_rd_q <= pin_level_in & ~chan_onehot;
      end
   end
   assign pin_drive_out  = pin_out_q;
   assign pin_drive_oe   = pin_oe_q;
   assign port_read_data = port_rd_q;

endmodule : sac_control
`default_nettype wire

// ==== sac_defs.svh ====
// Register offsets, field positions and reset values of the converter control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

`define SAC_OFF_STATUS_CTRL   12'h000
`define SAC_OFF_RESULT_HIGH   12'h004
`define SAC_OFF_RESULT_LOW    12'h008
`define SAC_OFF_CLOCK_CFG     12'h00C

`define SAC_SCR_FLAG_BIT      7
`define SAC_SCR_IRQEN_BIT     6
`define SAC_SCR_CONT_BIT      5
`define SAC_SCR_CHAN_MSB      4
`define SAC_SCR_RESET         8'h1F

`define SAC_CLK_DIV_MSB       7
`define SAC_CLK_DIV_LSB       5
`define SAC_CLK_INSEL_BIT     4
`define SAC_CLK_FMT_MSB       3
`define SAC_CLK_FMT_LSB       2
`define SAC_CLK_RESET         8'h00

`define SAC_CHAN_COUNT        24
`define SAC_CHAN_POWER_OFF    5'h1F
`define SAC_DIV_MAX           3'h4
`define SAC_RESULT_BITS       10
`define SAC_TRIAL_FIRST       4'h1
`define SAC_TRIAL_LAST        4'hA
`define SAC_CONV_LAST_TICK    4'hF

`endif

// ==== sac_pkg.sv ====
// Types shared by the converter control block.
// Assumes the definitions header is on the include path.
`include "sac_defs.svh"

package sac_pkg;

   // Result formats selected by the two format bits of the clock register.
   typedef enum logic [1:0] {
      SAC_FMT_LEFT,
      SAC_FMT_RIGHT,
      SAC_FMT_LEFT_SIGNED,
      SAC_FMT_TRUNC8
   } sac_format_t;

   // States of the successive-approximation sequencer.
   typedef enum logic [1:0] {
      SAC_ST_IDLE,
      SAC_ST_RUN
   } sac_state_t;

endpackage : sac_pkg

// ==== sac_sar_engine.sv ====
// Successive-approximation sequencer that runs on converter clock enable pulses.
// Assumes an analog comparator answers the trial code on cmp_above before the next tick.
`timescale 1ns/1ns
`default_nettype none
`include "sac_defs.svh"

module sac_sar_engine
   import sac_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       conv_tick,
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic       cmp_above,
   output logic [9:0]      trial_code,
   output logic            sample_hold,
   output logic            busy,
   output logic            done,
   output logic [9:0]      result
);

   sac_state_t state_q;
   logic [3:0] tick_cnt_q;
   logic [9:0] sar_q;
   logic [9:0] trial_bit;
   logic [3:0] bit_pos;

   // Bit under trial walks from the top bit down during ticks one to ten.
   assign bit_pos    = 4'(`SAC_TRIAL_LAST - tick_cnt_q);
   assign trial_bit  = (tick_cnt_q >= `SAC_TRIAL_FIRST && tick_cnt_q <= `SAC_TRIAL_LAST) ?
                       (10'h001 << bit_pos) : 10'h000;
   assign trial_code = sar_q | trial_bit;
   assign busy       = (state_q == SAC_ST_RUN);

   // Sequencer: a start restarts from tick zero, so a run takes sixteen ticks after alignment.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= SAC_ST_IDLE;
         tick_cnt_q <= 4'h0;
         sar_q      <= 10'h000;
      end else if (abort) begin
         state_q    <= SAC_ST_IDLE;
         tick_cnt_q <= 4'h0;
      end else if (start) begin
         state_q    <= SAC_ST_RUN;
         tick_cnt_q <= 4'h0;
         sar_q      <= 10'h000;
      end else if (state_q == SAC_ST_RUN && conv_tick) begin
         if (cmp_above) begin
            sar_q <= trial_code;
         end
         if (tick_cnt_q == `SAC_CONV_LAST_TICK) begin
            state_q    <= SAC_ST_IDLE;
            tick_cnt_q <= 4'h0;
         end else begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
         end
      end
   end

   // Completion pulse and held result, both registered.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done        <= 1'b0;
         result      <= 10'h000;
         sample_hold <= 1'b0;
      end else begin
         done        <= !abort && !start && busy && conv_tick &&
                        tick_cnt_q == `SAC_CONV_LAST_TICK;
         sample_hold <= busy && tick_cnt_q == 4'h0 && !abort;
         if (!abort && !start && busy && conv_tick && tick_cnt_q == `SAC_CONV_LAST_TICK) begin
            result <= sar_q;
         end
      end
   end

endmodule : sac_sar_engine
`default_nettype wire

// ==== sac_control_monitor.sv ====
// Checker of the converter control block ports.
// Assumes binding to sac_control, one clock and an active-low reset.
`timescale 1ns/1ns
`default_nettype none
module sac_control_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        stop_mode,
   input wire logic [4:0]  mux_select,
   input wire logic        sample_hold,
   input wire logic        conv_power_down,
   input wire logic        conv_irq,
   input wire logic [23:0] pin_analog_sel,
   input wire logic [23:0] port_dir_out,
   input wire logic [23:0] pin_level_in,
   input wire logic [23:0] pin_drive_oe,
   input wire logic [23:0] port_read_data,
   input wire logic [23:0] port_data_out,
   input wire logic [23:0] pin_drive_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access-phase decodes shared by the properties.
   wire acc = psel && penable;
   wire ctl_wr = acc && pwrite && paddr == 12'h000 && pstrb[0];
   wire res_rd = acc && !pwrite && (paddr == 12'h004 || paddr == 12'h008);
   a_err_unmapped: assert property (acc |-> pslverr == !(paddr == 12'h000 ||
      paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00C))
      else $error("slave error does not match address map");
   a_data_upper_zero: assert property (acc |-> prdata[31:8] == 24'h0)
      else $error("read data above the byte lane not zero");
   a_chan_one_hot: assert property (pin_analog_sel == ((mux_select < 5'h18) ? 24'h1 << mux_select : 24'h0))
      else $error("pin takeover does not match channel");
   a_drive_oe_masked: assert property ($past(presetn) |-> pin_drive_oe == ($past(port_dir_out) & ~$past(pin_analog_sel)))
      else $error("selected pin still driven by port");
   a_drive_out_masked: assert property ($past(presetn) |->
      pin_drive_out == ($past(port_data_out) & ~$past(pin_analog_sel)))
      else $error("selected pin still shows port data");
   a_read_masked: assert property ($past(presetn) |-> port_read_data == ($past(pin_level_in) & ~$past(pin_analog_sel)))
      else $error("port read of selected pin not zero");
   a_power_down_map: assert property (conv_power_down == (mux_select == 5'h1F || stop_mode))
      else $error("power down does not follow channel or stop");
   a_start_samples: assert property (ctl_wr && pwdata[4:0] != 5'h1F && !stop_mode |-> ##[1:2] sample_hold)
      else $error("control write did not start sampling");
   a_stop_quiet: assert property (stop_mode [*3] |-> !sample_hold)
      else $error("converter sampling during stop");
   a_irq_read_clear: assert property (res_rd |=> !conv_irq)
      else $error("result read left interrupt pending");
   // Main scenarios seen at the ports.
   c_irq_raised: cover property ($rose(conv_irq));
   c_result_read: cover property (res_rd);
   c_bus_error: cover property (acc && pslverr);
endmodule : sac_control_monitor
`default_nettype wire

bind sac_control sac_control_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pslverr, .stop_mode, .mux_select, .sample_hold, .conv_power_down,
   .conv_irq, .pin_analog_sel, .port_dir_out, .pin_level_in, .pin_drive_oe, .port_read_data,
   .port_data_out, .pin_drive_out);

// ==== sac_afe_model.sv ====
// Analog front end model: input mux, sample-and-hold and comparator.
// Assumes the bench sets the channel levels and the block drives trial codes on pclk.
`timescale 1ns/1ns
`default_nettype none
module sac_afe_model (
   input  wire logic       pclk,
   input  wire logic [4:0] mux_select,
   input  wire logic       sample_hold,
   input  wire logic [9:0] trial_code,
   output logic            cmp_above
);
   logic [9:0] level [0:23];
   logic [9:0] vin;
   logic [9:0] held_q;
   // Mux picks one external level or an internal reference.
   always_comb begin
      if (mux_select < 5'h18)
         vin = level[mux_select];
      else if (mux_select == 5'h1D)
         vin = 10'h3FF;
      else
         vin = 10'h000;
   end
   // Track the input while sampling and hold it afterwards, so a trial that falls in the
   // sampling cycle already sees the new level and later level changes do not disturb it.
   always_ff @(posedge pclk) begin
      if (sample_hold)
         held_q <= vin;
   end
   // Ideal comparator gives a linear transfer with no missing codes.
   assign cmp_above = (sample_hold ? vin : held_q) >= trial_code;
endmodule : sac_afe_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the converter control block.
// Assumes the analog model answers the comparator and the bench is the APB master.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import sac_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        wait_mode = 1'b0, stop_mode = 1'b0, err;
   logic [23:0] port_data_out = 24'h0, port_dir_out = 24'h0, pin_level_in = 24'h0;
   logic        pready, pslverr, cmp_above, sample_hold, conv_irq, conv_power_down;
   logic [4:0]  mux_select;
   logic [9:0]  trial_code;
   int          mismatches = 0, n_checks = 0, cyc = 0;

   sac_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hF), .prdata, .pready, .pslverr, .wait_mode, .stop_mode, .cmp_above,
      .mux_select, .trial_code, .sample_hold, .conv_power_down, .conv_irq,
      .pin_analog_sel(), .port_data_out, .port_dir_out, .pin_level_in,
      .pin_drive_out(), .pin_drive_oe(), .port_read_data());
   sac_afe_model u_afe (.pclk, .mux_select, .sample_hold, .trial_code, .cmp_above);

   // Clock, random port traffic and the hang limit.
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      port_data_out <= 24'($urandom);
      port_dir_out <= 24'($urandom);
      pin_level_in <= 24'($urandom);
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      if (mismatches == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer, held until pready is sampled high, then one idle edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Abandoned start on a neighbour channel, real start, then an 18-cycle wait, past the documented conversion time.
   task automatic conv(input logic [4:0] ch, input logic [1:0] mode);
      apb(1'b1, 12'h000, {24'h0, 3'b000, ch ^ 5'h01});
      apb(1'b1, 12'h000, {24'h0, 1'b0, mode, ch});
      repeat (18) @(posedge pclk);
   endtask : conv

   // Expected high and low result bytes for a format.
   function automatic logic [15:0] fmt_exp(input logic [1:0] f, input logic [9:0] r);
      case (f)
         2'h0: return {r[9:2], r[1:0], 6'h00};
         2'h1: return {6'h00, r[9:8], r[7:0]};
         2'h2: return {~r[9], r[8:2], r[1:0], 6'h00};
         default: return {8'h00, r[9:2]};
      endcase
   endfunction : fmt_exp

   initial begin
      logic [15:0] e;
      logic [9:0]  lv;
      logic [4:0]  ch;
      void'($urandom(63849));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values and an unmapped address.
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h1F);
      chk(32'(conv_power_down), 32'h1);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h010, 32'hFF);
      chk(32'(err), 32'h1);
      // Every format on random channels, then both internal references.
      for (int i = 0; i < 10; i++) begin
         ch = (i == 8) ? 5'h1D : (i == 9) ? 5'h1E : 5'($urandom_range(23));
         lv = (i == 8) ? 10'h3FF : (i == 9) ? 10'h000 : 10'($urandom);
         if (i < 8) begin
            u_afe.level[ch] = lv;
            u_afe.level[ch ^ 5'h01] = ~lv;
         end
         wait_mode <= i[0];
         apb(1'b1, 12'h00C, {28'h0, i[1:0], 2'b00});
         conv(ch, 2'b00);
         chk(32'(mux_select), 32'(ch));
         chk(32'(sample_hold), 32'h0);
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, {24'h0, 3'b100, ch});
         e = fmt_exp(i[1:0], lv);
         apb(1'b0, 12'h004, 32'h0);
         chk(rd, {24'h0, e[15:8]});
         apb(1'b0, 12'h008, 32'h0);
         chk(rd, {24'h0, e[7:0]});
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, {24'h0, 3'b000, ch});
      end
      // High read locks left format results; truncation has no lock.
      for (int f = 0; f < 4; f += 3) begin
         apb(1'b1, 12'h00C, {28'h0, f[1:0], 2'b00});
         lv = 10'($urandom);
         u_afe.level[5] = lv;
         conv(5'h05, 2'b00);
         apb(1'b0, 12'h004, 32'h0);
         u_afe.level[5] = ~lv;
         conv(5'h05, 2'b00);
         apb(1'b0, 12'h008, 32'h0);
         e = fmt_exp(f[1:0], (f == 3) ? ~lv : lv);
         chk(rd, {24'h0, e[7:0]});
      end
      // Continuous mode overwrites unread results.
      apb(1'b1, 12'h00C, 32'h4);
      u_afe.level[3] = 10'h155;
      conv(5'h03, 2'b01);
      u_afe.level[3] = 10'h2AA;
      repeat (40) @(posedge pclk);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'hAA);
      apb(1'b1, 12'h000, 32'h1F);
      // Interrupt mode: flag reads zero, read and write clear the request.
      conv(5'h02, 2'b10);
      chk(32'(conv_irq), 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h42);
      apb(1'b0, 12'h008, 32'h0);
      chk(32'(conv_irq), 32'h0);
      conv(5'h02, 2'b10);
      apb(1'b1, 12'h000, 32'h5F);
      chk(32'(conv_irq), 32'h0);
      chk(32'(conv_power_down), 32'h1);
      // Stop mode aborts a running conversion.
      conv(5'h06, 2'b00);
      apb(1'b0, 12'h008, 32'h0);
      apb(1'b1, 12'h000, 32'h06);
      stop_mode <= 1'b1;
      repeat (30) @(posedge pclk);
      stop_mode <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h06);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
